// ---- core/thsm_core.v ----
// Transparent receive hunt, transmit fill and transmit slot mask block
`timescale 1ns/10ps
`include "thsm_map.vh"
module thsm_core (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Microprocessor port pins
	input wire [4:0] cpu_addr,
	input wire cpu_cs_n,
	input wire cpu_wr_n,
	input wire cpu_rd_n,
	input wire [7:0] cpu_d_in,
	output reg [7:0] cpu_d_out_q,
	output reg cpu_d_oe_q,
	// Mode selects from the rest of the controller
	input wire transparent_sel,
	input wire hunt_en,
	input wire octet_align_sel,
	input wire highway_en,
	input wire tx_bit_order_sel,
	input wire link_en,
	input wire hwy_slot,
	// Highway pins
	input wire link_clk,
	input wire link_rx,
	output reg link_tx_q,
	output reg link_tx_oe_q,
	// Receive buffer side
	output reg [7:0] rx_data_q,
	output reg rx_wr_q,
	input wire rx_full,
	output reg rx_overrun_irq_q,
	// Transmit buffer side
	input wire [7:0] tx_data,
	input wire tx_vld,
	output reg tx_rd_q,
	// Framing engine side
	output reg hdlc_rx_bit_q,
	output reg hdlc_rx_vld_q,
	input wire hdlc_tx_bit,
	output reg hdlc_tx_req_q,
	// Interrupt enables and hunt found status
	output reg [7:0] irq_mask_q,
	output reg hunt_found_q
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function hit;
		input [4:0] a;
		input [4:0] r;
		begin
			hit = (a == r);
		end
	endfunction

	// Position in serial order to significance index
	function [2:0] sig_idx;
		input [2:0] pos;
		input msb_first;
		begin
			sig_idx = msb_first ? (3'h7 - pos) : pos;
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Strobes and link clock idle high, so they reset high to avoid a false edge
	wire [17:0] pins_s;

	thsm_sync #(
		.WIDTH(18),
		.RST_VAL(18'h2E000)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.async_in({link_clk, link_rx, cpu_cs_n, cpu_wr_n, cpu_rd_n,
			cpu_addr, cpu_d_in}),
		.sync_q(pins_s)
	);

	wire lclk_s = pins_s[17];
	wire rxd_s = pins_s[16];
	wire cs_n_s = pins_s[15];
	wire wr_n_s = pins_s[14];
	wire rd_n_s = pins_s[13];
	wire [4:0] addr_s = pins_s[12:8];
	wire [7:0] din_s = pins_s[7:0];

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	reg [7:0] hunt_pat_q;
	reg [7:0] slot_gate_q;
	reg [7:0] fill_char_q;
	reg wr_n_prev_q;
	reg [7:0] rd_mux;

	// Write commits on the rising edge of the write strobe
	wire wr_commit = wr_n_s & ~wr_n_prev_q & ~cs_n_s;

	always @*
	begin
		rd_mux = 8'h00;
		if (hit(addr_s, `THSM_ADDR_SLOT_GATE))
			rd_mux = slot_gate_q;
		else if (hit(addr_s, `THSM_ADDR_IRQ_MASK))
			rd_mux = irq_mask_q;
		else if (hit(addr_s, `THSM_ADDR_HUNT_PAT))
			rd_mux = hunt_pat_q;
		else if (hit(addr_s, `THSM_ADDR_FILL_CHAR))
			rd_mux = fill_char_q;
	end

	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			hunt_pat_q <= `THSM_RST_HUNT_PAT;
			slot_gate_q <= `THSM_RST_SLOT_GATE;
			fill_char_q <= `THSM_RST_FILL_CHAR;
			irq_mask_q <= `THSM_RST_IRQ_MASK;
			wr_n_prev_q <= 1'b1;
			cpu_d_out_q <= 8'h00;
			cpu_d_oe_q <= 1'b0;
		end
		else
		begin
			wr_n_prev_q <= wr_n_s;
			cpu_d_oe_q <= ~cs_n_s & ~rd_n_s;
			cpu_d_out_q <= rd_mux;
			if (wr_commit)
			begin
				if (hit(addr_s, `THSM_ADDR_SLOT_GATE))
					slot_gate_q <= din_s;
				if (hit(addr_s, `THSM_ADDR_IRQ_MASK))
					irq_mask_q <= din_s;
				if (hit(addr_s, `THSM_ADDR_HUNT_PAT))
					hunt_pat_q <= din_s;
				if (hit(addr_s, `THSM_ADDR_FILL_CHAR))
					fill_char_q <= din_s;
			end
		end
	end

	// ----------------------------------------
	// Link clock edges
	// ----------------------------------------
	reg lclk_prev_q;
	wire lclk_rise = lclk_s & ~lclk_prev_q;
	wire lclk_fall = ~lclk_s & lclk_prev_q;

	// Outside highway mode every bit time belongs to this device
	wire bit_ok = link_en & (~highway_en | hwy_slot);

	always @(posedge clk_sys)
	begin
		if (!resetn)
			lclk_prev_q <= 1'b1;
		else
			lclk_prev_q <= lclk_s;
	end

	// ----------------------------------------
	// Receive hunt
	// ----------------------------------------
	reg [7:0] rx_sr_q;
	reg [2:0] rx_cnt_q;
	reg [7:0] rx_win;
	reg rx_match;
	reg rx_take;

	// Hunt applies only in transparent mode with hunt enabled
	wire hunting = transparent_sel & hunt_en & ~hunt_found_q;

	always @*
	begin
		rx_win = {rxd_s, rx_sr_q[7:1]};
		rx_match = 1'b0;
		rx_take = 1'b0;
		if (hunting)
		begin
			// Byte boundary compare only when octet align is selected
			if (octet_align_sel)
				rx_match = (rx_cnt_q == 3'h7) && (rx_win == hunt_pat_q);
			else
				rx_match = (rx_win == hunt_pat_q);
			rx_take = rx_match;
		end
		else
			rx_take = (rx_cnt_q == 3'h7);
	end

	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			rx_sr_q <= 8'h00;
			rx_cnt_q <= 3'h0;
			rx_data_q <= 8'h00;
			rx_wr_q <= 1'b0;
			rx_overrun_irq_q <= 1'b0;
			hunt_found_q <= 1'b0;
			hdlc_rx_bit_q <= 1'b0;
			hdlc_rx_vld_q <= 1'b0;
		end
		else
		begin
			rx_wr_q <= 1'b0;
			rx_overrun_irq_q <= 1'b0;
			hdlc_rx_vld_q <= 1'b0;
			if (!transparent_sel || !hunt_en)
				hunt_found_q <= 1'b0;
			// Octet boundary restarts at each slot or receiver enable
			if (!bit_ok)
				rx_cnt_q <= 3'h0;
			if (lclk_rise && bit_ok)
			begin
				if (!transparent_sel)
				begin
					// Framed mode: raw bits go to the framing engine
					hdlc_rx_bit_q <= rxd_s;
					hdlc_rx_vld_q <= 1'b1;
				end
				else
				begin
					rx_sr_q <= rx_win;
					rx_cnt_q <= rx_cnt_q + 3'h1;
					if (rx_take)
					begin
						rx_data_q <= rx_win;
						rx_wr_q <= 1'b1;
						rx_overrun_irq_q <= rx_full & irq_mask_q[`THSM_IM_RX_OVERRUN];
						rx_cnt_q <= 3'h0;
						if (hunting)
							hunt_found_q <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Transmit
	// ----------------------------------------
	reg [7:0] tx_sr_q;
	reg [2:0] tx_pos_q;
	reg [7:0] tx_next;
	reg tx_gate;

	// Empty buffer: programmed fill only with hunt enabled, else ones
	always @*
	begin
		if (tx_vld)
			tx_next = tx_data;
		else if (hunt_en)
			tx_next = fill_char_q;
		else
			tx_next = `THSM_ONES_IDLE;
	end

	// Gate by significance, not by position on the wire
	always @*
	begin
		if (highway_en)
			tx_gate = hwy_slot & slot_gate_q[sig_idx(tx_pos_q, tx_bit_order_sel)];
		else
			tx_gate = link_en;
	end

	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			tx_sr_q <= 8'h00;
			tx_pos_q <= 3'h0;
			tx_rd_q <= 1'b0;
			hdlc_tx_req_q <= 1'b0;
			link_tx_q <= 1'b1;
			link_tx_oe_q <= 1'b0;
		end
		else
		begin
			tx_rd_q <= 1'b0;
			hdlc_tx_req_q <= 1'b0;
			if (!bit_ok)
				tx_pos_q <= 3'h0;
			if (!bit_ok)
				link_tx_oe_q <= 1'b0;
			if (lclk_fall && bit_ok)
			begin
				link_tx_oe_q <= tx_gate;
				tx_pos_q <= tx_pos_q + 3'h1;
				if (!transparent_sel)
				begin
					link_tx_q <= hdlc_tx_bit;
					hdlc_tx_req_q <= 1'b1;
				end
				else if (tx_pos_q == 3'h0)
				begin
					// Load a byte at the start of each octet
					link_tx_q <= tx_bit_order_sel ? tx_next[7] : tx_next[0];
					tx_sr_q <= tx_next;
					tx_rd_q <= tx_vld;
				end
				else
					link_tx_q <= tx_sr_q[sig_idx(tx_pos_q, tx_bit_order_sel)];
			end
		end
	end

endmodule

// ---- core/thsm_map.vh ----
// Constants for the transparent hunt and transmit slot mask block
`ifndef THSM_MAP_VH
`define THSM_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define THSM_ADDR_W 5
`define THSM_ADDR_SLOT_GATE 5'h0D
`define THSM_ADDR_IRQ_MASK 5'h0E
`define THSM_ADDR_HUNT_PAT 5'h1C
`define THSM_ADDR_FILL_CHAR 5'h1D

// ----------------------------------------
// Reset values
// ----------------------------------------
`define THSM_RST_HUNT_PAT 8'h7E
`define THSM_RST_SLOT_GATE 8'h00
`define THSM_RST_FILL_CHAR 8'hFF
`define THSM_RST_IRQ_MASK 8'h00
`define THSM_ONES_IDLE 8'hFF

// ----------------------------------------
// Interrupt mask fields
// ----------------------------------------
`define THSM_IM_TX_DONE 0
`define THSM_IM_TX_EMPTY 1
`define THSM_IM_TX_UNDERRUN 2
`define THSM_IM_RX_FULL 3
`define THSM_IM_RX_FRAME_END 4
`define THSM_IM_RX_OVERRUN 5
`define THSM_IM_RX_IDLE 6
`define THSM_IM_BAD_CRC 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define THSM_SYNC_STAGES 2
`define THSM_BITS_PER_BYTE 4'h8

`endif

// ---- core/thsm_sync.v ----
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
module thsm_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Data
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_q
);

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	// First stage is read only by the second stage
	reg [WIDTH-1:0] meta_q;

	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule

// ---- tb/thsm_properties.sv ----
// Checker for the hunt and slot mask block
`timescale 1ns/10ps
module thsm_props (
	// Watched ports
	input wire clk_sys,
	input wire resetn,
	input wire transparent_sel,
	input wire hunt_en,
	input wire highway_en,
	input wire hwy_slot,
	input wire link_tx_q,
	input wire link_tx_oe_q,
	input wire rx_wr_q,
	input wire rx_overrun_irq_q,
	input wire tx_vld,
	input wire tx_rd_q,
	input wire [7:0] irq_mask_q,
	input wire hunt_found_q
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	property p_rst;
		$rose(resetn) |-> irq_mask_q == 8'h00 && link_tx_q && !link_tx_oe_q;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_slot_off;
		(highway_en && !hwy_slot)[*3] |-> !link_tx_oe_q;
	endproperty
	a_slot_off: assert property (p_slot_off) else $error("tx driven off slot");
	property p_hunt_hold;
		rx_wr_q && transparent_sel && hunt_en |-> hunt_found_q;
	endproperty
	a_hunt_hold: assert property (p_hunt_hold) else $error("write while hunting");
	property p_framed;
		!transparent_sel[*3] |-> !rx_wr_q;
	endproperty
	a_framed: assert property (p_framed) else $error("framed byte stored");
	property p_wr_pulse;
		rx_wr_q |=> !rx_wr_q;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write too long");
	property p_ovr;
		rx_overrun_irq_q |-> irq_mask_q[5] && (rx_wr_q || $past(rx_wr_q));
	endproperty
	a_ovr: assert property (p_ovr) else $error("stray overrun");
	property p_found_clr;
		!hunt_en[*2] |-> !hunt_found_q;
	endproperty
	a_found_clr: assert property (p_found_clr) else $error("found kept");
	property p_rd_vld;
		tx_rd_q |-> tx_vld || $past(tx_vld);
	endproperty
	a_rd_vld: assert property (p_rd_vld) else $error("take from empty");
endmodule
bind thsm_core thsm_props u_props (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.transparent_sel(transparent_sel),
	.hunt_en(hunt_en),
	.highway_en(highway_en),
	.hwy_slot(hwy_slot),
	.link_tx_q(link_tx_q),
	.link_tx_oe_q(link_tx_oe_q),
	.rx_wr_q(rx_wr_q),
	.rx_overrun_irq_q(rx_overrun_irq_q),
	.tx_vld(tx_vld),
	.tx_rd_q(tx_rd_q),
	.irq_mask_q(irq_mask_q),
	.hunt_found_q(hunt_found_q)
);

// ---- tb/thsm_link_model.sv ----
// Highway partner: bit clock, slot, receive bits, transmit capture
`timescale 1ns/10ps
module thsm_link_model (
	// Highway
	output logic link_clk,
	output logic link_rx,
	output logic hwy_slot,
	input wire link_tx_q,
	input wire link_tx_oe_q
);
	logic [7:0] tx_bits;
	logic [7:0] tx_oes;
	initial
	begin
		link_clk = 1'b1;
		link_rx = 1'b1;
		hwy_slot = 1'b0;
	end
	// Clock stands high between frames; sample late so slow syncs settle
	task automatic frame(input logic [31:0] b, input int n);
		hwy_slot = 1'b1;
		#20;
		for (int i = 0; i < n; i++)
		begin
			link_clk = 1'b0;
			link_rx = b[i];
			#80 link_clk = 1'b1;
			#70 tx_bits[i%8] = link_tx_q;
			tx_oes[i%8] = link_tx_oe_q;
			#10;
		end
		#100 hwy_slot = 1'b0;
		link_rx = ~link_rx;
	endtask
endmodule

// ---- tb/thsm_core_tb_top.sv ----
// Testbench for the hunt and slot mask block
`timescale 1ns/10ps
`include "thsm_map.vh"
`define CHK(e, s, w) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("wrong value %s exp %h got %h", w, e, s); end end
module thsm_core_tb_top;
	logic clk_sys, resetn, cpu_cs_n, cpu_wr_n, cpu_rd_n, transparent_sel, hunt_en;
	logic octet_align_sel, highway_en, tx_bit_order_sel, link_en, rx_full, tx_vld, hdlc_tx_bit;
	logic [4:0] cpu_addr;
	logic [7:0] cpu_d_in, tx_data, cpu_d_out_q, rx_data_q, irq_mask_q, e, d, p, f, m, im;
	logic cpu_d_oe_q, link_tx_q, link_tx_oe_q, rx_wr_q, rx_overrun_irq_q, tx_rd_q;
	logic hdlc_rx_bit_q, hdlc_rx_vld_q, hdlc_tx_req_q, hunt_found_q, link_clk, link_rx, hwy_slot;
	logic [7:0] rxq[$];
	int bad_count, n_checks, ovc, hrx, hro, htx, trd;
	thsm_core dut_u (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.cpu_addr(cpu_addr),
		.cpu_cs_n(cpu_cs_n),
		.cpu_wr_n(cpu_wr_n),
		.cpu_rd_n(cpu_rd_n),
		.cpu_d_in(cpu_d_in),
		.cpu_d_out_q(cpu_d_out_q),
		.cpu_d_oe_q(cpu_d_oe_q),
		.transparent_sel(transparent_sel),
		.hunt_en(hunt_en),
		.octet_align_sel(octet_align_sel),
		.highway_en(highway_en),
		.tx_bit_order_sel(tx_bit_order_sel),
		.link_en(link_en),
		.hwy_slot(hwy_slot),
		.link_clk(link_clk),
		.link_rx(link_rx),
		.link_tx_q(link_tx_q),
		.link_tx_oe_q(link_tx_oe_q),
		.rx_data_q(rx_data_q),
		.rx_wr_q(rx_wr_q),
		.rx_full(rx_full),
		.rx_overrun_irq_q(rx_overrun_irq_q),
		.tx_data(tx_data),
		.tx_vld(tx_vld),
		.tx_rd_q(tx_rd_q),
		.hdlc_rx_bit_q(hdlc_rx_bit_q),
		.hdlc_rx_vld_q(hdlc_rx_vld_q),
		.hdlc_tx_bit(hdlc_tx_bit),
		.hdlc_tx_req_q(hdlc_tx_req_q),
		.irq_mask_q(irq_mask_q),
		.hunt_found_q(hunt_found_q)
	);
	thsm_link_model lm (
		.link_clk(link_clk),
		.link_rx(link_rx),
		.hwy_slot(hwy_slot),
		.link_tx_q(link_tx_q),
		.link_tx_oe_q(link_tx_oe_q)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Strobes are held long enough for the pin synchronisers
	task automatic wr(input logic [4:0] a, input logic [7:0] x);
		cpu_addr = a;
		cpu_d_in = x;
		cpu_cs_n = 1'b0;
		cpu_wr_n = 1'b0;
		cyc(4);
		cpu_wr_n = 1'b1;
		cyc(4);
		cpu_cs_n = 1'b1;
		cyc(4);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] x);
		cpu_addr = a;
		cpu_cs_n = 1'b0;
		cpu_rd_n = 1'b0;
		cyc(5);
		`CHK(x, cpu_d_out_q, "reg read")
		`CHK(1'b1, cpu_d_oe_q, "read enable")
		cpu_rd_n = 1'b1;
		cpu_cs_n = 1'b1;
		cyc(5);
		`CHK(1'b0, cpu_d_oe_q, "read release")
	endtask
	task automatic txf(input logic [7:0] v, input logic [7:0] g);
		int j;
		if (!hunt_en)
			rxq.push_back(8'h00);
		lm.frame(32'h0, 8);
		for (int k = 0; k < 8; k++)
		begin
			j = tx_bit_order_sel ? 7 - k : k;
			`CHK(g[j], lm.tx_oes[k], "tx enable")
			if (g[j]) `CHK(v[j], lm.tx_bits[k], "tx bit")
		end
	endtask
	always @(posedge clk_sys)
	begin
		if (tx_rd_q)
			trd++;
		if (rx_overrun_irq_q)
			ovc++;
		if (hdlc_rx_vld_q)
		begin
			hrx++;
			hro += hdlc_rx_bit_q;
		end
		if (hdlc_tx_req_q)
			htx++;
		if (rx_wr_q)
		begin
			e = rxq.size() ? rxq.pop_front() : 8'hXX;
			`CHK(e, rx_data_q, "rx byte")
		end
	end
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#1000000;
		bad_count++;
		final_report();
	end
	// ----------
	// Main sequence
	// ----------
	initial
	begin
		{resetn, cpu_addr, cpu_d_in, tx_data, transparent_sel, hunt_en, octet_align_sel} = '0;
		{highway_en, tx_bit_order_sel, link_en, rx_full, tx_vld, hdlc_tx_bit} = '0;
		{cpu_cs_n, cpu_wr_n, cpu_rd_n} = 3'h7;
		void'($urandom(86));
		cyc(8);
		resetn = 1'b1;
		cyc(3);
		rd(`THSM_ADDR_HUNT_PAT, 8'h7E);
		rd(`THSM_ADDR_SLOT_GATE, 8'h00);
		rd(`THSM_ADDR_FILL_CHAR, 8'hFF);
		rd(`THSM_ADDR_IRQ_MASK, 8'h00);
		{transparent_sel, hunt_en, link_en} = 3'h7;
		d = 8'($urandom);
		rxq = '{8'h7E, d};
		lm.frame({d, 8'h7E, 3'h0}, 19);
		`CHK(1'b1, hunt_found_q, "hunt found")
		transparent_sel = 1'b0;
		lm.frame(32'h7E, 8);
		`CHK(1'b0, hunt_found_q, "hunt cleared")
		`CHK(8, hrx, "framed bit strobes")
		`CHK(6, hro, "framed ones")
		`CHK(8, htx, "framed tx requests")
		`CHK(8'h00, lm.tx_bits, "framed tx bits")
		{transparent_sel, highway_en, octet_align_sel} = 3'h7;
		rxq.push_back(8'h7E);
		lm.frame(32'hE0, 8);
		lm.frame(32'h07, 8);
		lm.frame(32'h7E, 8);
		hunt_en = 1'b0;
		wr(`THSM_ADDR_IRQ_MASK, 8'h20);
		rx_full = 1'b1;
		rxq.push_back(d);
		lm.frame(32'(d), 8);
		cyc(8);
		`CHK(1, ovc, "overrun pulses")
		rx_full = 1'b0;
		hunt_en = 1'b1;
		txf(8'hFF, 8'h00);
		highway_en = 1'b0;
		txf(8'hFF, 8'hFF);
		p = 8'($urandom) | 8'h01;
		f = 8'($urandom);
		m = 8'($urandom);
		im = 8'($urandom);
		wr(`THSM_ADDR_HUNT_PAT, p);
		wr(`THSM_ADDR_FILL_CHAR, f);
		wr(`THSM_ADDR_SLOT_GATE, m);
		wr(`THSM_ADDR_IRQ_MASK, im);
		wr(5'h00, 8'hA5);
		rd(`THSM_ADDR_HUNT_PAT, p);
		rd(`THSM_ADDR_FILL_CHAR, f);
		rd(`THSM_ADDR_SLOT_GATE, m);
		rd(`THSM_ADDR_IRQ_MASK, im);
		rd(5'h00, 8'h00);
		`CHK(im, irq_mask_q, "mask port")
		highway_en = 1'b1;
		for (int o = 0; o < 2; o++)
		begin
			tx_bit_order_sel = o[0];
			txf(f, m);
			tx_data = 8'($urandom);
			tx_vld = 1'b1;
			txf(tx_data, m);
			tx_vld = 1'b0;
			hunt_en = 1'b0;
			txf(8'hFF, m);
			hunt_en = 1'b1;
		end
		`CHK(2, trd, "tx takes")
		final_report();
	end
endmodule
